// *** design/fmd_cfg.svh ***
`ifndef FMD_CFG_SVH
`define FMD_CFG_SVH

// Storage geometry
`define FMD_WORD_W      12
`define FMD_ADDR_W      18
`define FMD_DEPTH       262144
`define FMD_FIFO_DEPTH  8

// Write-to-read lag limits, in write clock cycles
`define FMD_OLD_LIMIT   16'h0046
`define FMD_NEW_LIMIT   16'h0258
`define FMD_LAG_MAX     16'hFFFF
`define FMD_LAG_ONE     16'h0001
`define FMD_OLD_DEPTH   70

// APB register map
`define FMD_OFS_CTRL    12'h000
`define FMD_OFS_WPTR    12'h004
`define FMD_OFS_RPTR    12'h008
`define FMD_OFS_LAG     12'h00C

// Control fields
`define FMD_CTRL_RST    2'h1
`define FMD_CTRL_EN     0
`define FMD_CTRL_OFF    1

// Lag register fields
`define FMD_LAG_WIN_LO  16
`define FMD_LAG_WIN_HI  17
`define FMD_LAG_OVF     18

`endif

// *** design/fmd_pkg.sv ***
`default_nettype none
`include "fmd_cfg.svh"

package fmd_pkg;

  typedef logic [`FMD_WORD_W-1:0] fmd_word_t;
  typedef logic [`FMD_ADDR_W-1:0] fmd_addr_t;
  typedef logic [15:0]            fmd_lag_t;

  // Gray codes along idle, old, mixed, new
  typedef enum logic [1:0] {
    FMD_WIN_IDLE = 2'h0,
    FMD_WIN_OLD  = 2'h1,
    FMD_WIN_MIX  = 2'h3,
    FMD_WIN_NEW  = 2'h2
  } fmd_win_t;

endpackage

`default_nettype wire

// *** design/fmd_field_memory.sv ***
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "fmd_cfg.svh"

module fmd_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = `FMD_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_reset,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [PW:0]      next_count;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count != FULL);
  assign o_out_valid = (count != '0);
  assign o_out_data  = store[rd_ptr];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST) ? '0 : PW'(wr_ptr + 1'b1);
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST) ? '0 : PW'(rd_ptr + 1'b1);
    end
    if (push && !pop) begin
      next_count = (PW + 1)'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = (PW + 1)'(count - 1'b1);
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      store[wr_ptr] <= i_in_data;
    end
  end
endmodule

module fmd_field_memory #(
  parameter int DEPTH      = `FMD_DEPTH,
  parameter int ADDR_W     = `FMD_ADDR_W,
  parameter int DL_DEPTH   = `FMD_OLD_DEPTH,
  parameter int FIFO_DEPTH = `FMD_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_reset,
  // APB slave
  input  wire logic          i_psel,
  input  wire logic          i_penable,
  input  wire logic          i_pwrite,
  input  wire logic [11:0]   i_paddr,
  input  wire logic [31:0]   i_pwdata,
  output logic [31:0]        o_prdata,
  output logic               o_pready,
  output logic               o_pslverr,
  // Write port pins
  input  wire logic          i_serial_write_clock,
  input  wire logic          i_write_pointer_reset,
  input  wire logic          i_write_gate,
  input  wire logic          i_input_mask,
  input  wire fmd_pkg::fmd_word_t i_input_word,
  // Read port pins
  input  wire logic          i_serial_read_clock,
  input  wire logic          i_read_pointer_reset,
  input  wire logic          i_read_gate,
  input  wire logic          i_output_gate,
  output fmd_pkg::fmd_word_t o_output_word,
  output logic               o_output_word_oe
);
  import fmd_pkg::*;

  localparam int WW  = `FMD_WORD_W;
  localparam int FW  = ADDR_W + WW;
  localparam int DLW = FW + 1;
  localparam logic [ADDR_W-1:0] ALAST = ADDR_W'(DEPTH - 1);

  logic [WW+3:0]     w_meta;
  logic [WW+3:0]     w_sync;
  logic              w_clk_q;
  logic [3:0]        r_meta;
  logic [3:0]        r_sync;
  logic              r_clk_q;
  logic              w_edge;
  logic              r_edge;
  logic [1:0]        ctrl;
  logic [1:0]        next_ctrl;
  logic [ADDR_W-1:0] waddr;
  logic [ADDR_W-1:0] next_waddr;
  logic [ADDR_W-1:0] raddr;
  logic [ADDR_W-1:0] next_raddr;
  fmd_lag_t          wlag;
  fmd_lag_t          next_wlag;
  fmd_lag_t          lag;
  fmd_lag_t          next_lag;
  fmd_win_t          win;
  fmd_win_t          next_win;
  logic              wseen;
  logic              next_wseen;
  logic              ovf;
  logic              next_ovf;
  logic              dl_shift;
  logic              rd_fire;
  fmd_word_t         next_word;
  logic              next_oe;
  logic [31:0]       next_prdata;
  logic [DLW-1:0]    dl [DL_DEPTH];
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [FW-1:0]     fifo_out_data;
  logic              mem_we;
  fmd_word_t         mem [DEPTH];
  logic              apb_setup;
  logic              apb_access;
  logic              mapped;

  // Pin synchronisers and clock edge detect
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      w_meta  <= '0;
      w_sync  <= '0;
      w_clk_q <= 1'b0;
      r_meta  <= '0;
      r_sync  <= '0;
      r_clk_q <= 1'b0;
    end else begin
      w_meta  <= {i_serial_write_clock, i_write_pointer_reset, i_write_gate, i_input_mask, i_input_word};
      w_sync  <= w_meta;
      w_clk_q <= w_sync[WW+3];
      r_meta  <= {i_serial_read_clock, i_read_pointer_reset, i_read_gate, i_output_gate};
      r_sync  <= r_meta;
      r_clk_q <= r_sync[3];
    end
  end

  assign w_edge = w_sync[WW+3] & ~w_clk_q & ctrl[`FMD_CTRL_EN];
  assign r_edge = r_sync[3] & ~r_clk_q & ctrl[`FMD_CTRL_EN];

  // Write pointer and lag counter
  always_comb begin
    next_waddr = waddr;
    next_wlag  = wlag;
    next_wseen = wseen;
    dl_shift   = 1'b0;
    if (w_edge) begin
      if (w_sync[WW+2]) begin
        next_waddr = '0;
        next_wlag  = '0;
        next_wseen = 1'b1;
      end else begin
        if (w_sync[WW+1]) begin
          next_waddr = (waddr == ALAST) ? '0 : ADDR_W'(waddr + 1'b1);
          dl_shift   = 1'b1;
        end
        if (wlag != `FMD_LAG_MAX) begin
          next_wlag = wlag + `FMD_LAG_ONE;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      waddr <= '0;
      wlag  <= '0;
      wseen <= 1'b0;
    end else begin
      waddr <= next_waddr;
      wlag  <= next_wlag;
      wseen <= next_wseen;
    end
  end

  // Commit delay line keeps the previous field readable after a write reset
  genvar gi;
  generate
    for (gi = 0; gi < DL_DEPTH; gi++) begin : g_dl
      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          dl[gi] <= '0;
        end else if (dl_shift) begin
          if (gi == 0) begin
            dl[gi] <= {w_sync[WW], waddr, w_sync[WW-1:0]};
          end else begin
            dl[gi] <= dl[(gi > 0) ? gi - 1 : 0];
          end
        end
      end
    end
  endgenerate

  fmd_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_reset     (i_reset),
    .i_in_valid  (dl_shift & dl[DL_DEPTH-1][DLW-1]),
    .i_in_data   (dl[DL_DEPTH-1][FW-1:0]),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (~rd_fire)
  );

  // Array write yields to a read fetch, never dropped
  assign mem_we = fifo_out_valid & ~rd_fire;

  always_ff @(posedge i_core_clk) begin
    if (mem_we) begin
      mem[fifo_out_data[FW-1:WW]] <= fifo_out_data[WW-1:0];
    end
  end

  // Read pointer, output word and enable
  always_comb begin
    next_raddr = raddr;
    next_word  = o_output_word;
    next_oe    = o_output_word_oe;
    rd_fire    = 1'b0;
    if (r_edge) begin
      next_oe = r_sync[0] & ~ctrl[`FMD_CTRL_OFF];
      if (r_sync[2]) begin
        next_raddr = '0;
      end else if (r_sync[1]) begin
        rd_fire    = 1'b1;
        next_word  = mem[raddr];
        next_raddr = (raddr == ALAST) ? '0 : ADDR_W'(raddr + 1'b1);
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      raddr            <= '0;
      o_output_word    <= '0;
      o_output_word_oe <= 1'b0;
    end else begin
      raddr            <= next_raddr;
      o_output_word    <= next_word;
      o_output_word_oe <= next_oe;
    end
  end

  // Lag window capture at read reset
  always_comb begin
    next_lag = lag;
    next_win = win;
    if (r_edge && r_sync[2] && wseen) begin
      next_lag = wlag;
      if (wlag < `FMD_OLD_LIMIT) begin
        next_win = FMD_WIN_OLD;
      end else if (wlag < `FMD_NEW_LIMIT) begin
        next_win = FMD_WIN_MIX;
      end else begin
        next_win = FMD_WIN_NEW;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      lag <= '0;
      win <= FMD_WIN_IDLE;
    end else begin
      lag <= next_lag;
      win <= next_win;
    end
  end

  // APB slave
  assign apb_setup  = i_psel & ~i_penable;
  assign apb_access = i_psel & i_penable;
  assign mapped     = (i_paddr == `FMD_OFS_CTRL) | (i_paddr == `FMD_OFS_WPTR) |
                      (i_paddr == `FMD_OFS_RPTR) | (i_paddr == `FMD_OFS_LAG);
  assign o_pready   = 1'b1;
  assign o_pslverr  = apb_access & ~mapped;

  always_comb begin
    next_ctrl   = ctrl;
    next_ovf    = ovf;
    next_prdata = o_prdata;
    if (apb_access && i_pwrite && i_paddr == `FMD_OFS_CTRL) begin
      next_ctrl = i_pwdata[1:0];
    end
    if (apb_access && i_pwrite && i_paddr == `FMD_OFS_LAG && i_pwdata[`FMD_LAG_OVF]) begin
      next_ovf = 1'b0;
    end
    if (dl_shift && dl[DL_DEPTH-1][DLW-1] && !fifo_in_ready) begin
      next_ovf = 1'b1;
    end
    if (apb_setup) begin
      next_prdata = '0;
      unique case (i_paddr)
        `FMD_OFS_CTRL: next_prdata[1:0]        = ctrl;
        `FMD_OFS_WPTR: next_prdata[ADDR_W-1:0] = waddr;
        `FMD_OFS_RPTR: next_prdata[ADDR_W-1:0] = raddr;
        `FMD_OFS_LAG:  next_prdata = {13'h0000, ovf, win, lag};
        default:       next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl     <= `FMD_CTRL_RST;
      ovf      <= 1'b0;
      o_prdata <= '0;
    end else begin
      ctrl     <= next_ctrl;
      ovf      <= next_ovf;
      o_prdata <= next_prdata;
    end
  end

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  waddr_clear_a: assert property (w_edge && w_sync[WW+2] |=> waddr == '0)
    else $error("write address not cleared by write reset");
  raddr_clear_a: assert property (r_edge && r_sync[2] |=> raddr == '0)
    else $error("read address not cleared by read reset");
  wgate_hold_a: assert property (w_edge && !w_sync[WW+2] && !w_sync[WW+1] |=> $stable(waddr))
    else $error("write address moved with write gate low");
  mask_advance_a: assert property (w_edge && !w_sync[WW+2] && w_sync[WW+1] && waddr != ALAST
                                   |=> waddr == $past(waddr) + 1'b1)
    else $error("write address did not advance");
  rgate_hold_a: assert property (r_edge && !r_sync[2] && !r_sync[1] |=> $stable(raddr))
    else $error("read address moved with read gate low");
  oe_follow_a: assert property (r_edge |=> o_output_word_oe == ($past(r_sync[0]) && !$past(ctrl[`FMD_CTRL_OFF])))
    else $error("output enable does not follow output gate");
  old_window_a: assert property (r_edge && r_sync[2] && wseen && wlag < `FMD_OLD_LIMIT
                                 |=> win == FMD_WIN_OLD && lag == $past(wlag))
    else $error("short lag not classed as old data");
  mix_window_a: assert property (r_edge && r_sync[2] && wseen && wlag >= `FMD_OLD_LIMIT
                                 && wlag < `FMD_NEW_LIMIT |=> win == FMD_WIN_MIX)
    else $error("middle lag not classed as undetermined");
  new_window_a: assert property (r_edge && r_sync[2] && wseen && wlag >= `FMD_NEW_LIMIT
                                 |=> win == FMD_WIN_NEW)
    else $error("long lag not classed as new data");
  write_commit_a: assert property (mem_we |=> mem[$past(fifo_out_data[FW-1:WW])] == $past(fifo_out_data[WW-1:0]))
    else $error("queued write not stored");

  old_read_c: cover property (r_edge && r_sync[2] && wseen && wlag < `FMD_OLD_LIMIT);
  new_read_c: cover property (r_edge && r_sync[2] && wseen && wlag >= `FMD_NEW_LIMIT);
  write_stall_c: cover property (fifo_out_valid && rd_fire);
  masked_write_c: cover property (w_edge && w_sync[WW+1] && !w_sync[WW]);
endmodule

`default_nettype wire

// *** testbench/fmd_video_drv.sv ***
`timescale 1ns/100ps
`default_nettype none
module fmd_video_drv (
  // Core clock
  input  wire logic               i_core_clk,
  // Write port
  output logic                    o_wclk,
  output logic                    o_wrst,
  output logic                    o_wgate,
  output logic                    o_imask,
  output fmd_pkg::fmd_word_t      o_wdata,
  // Read port
  output logic                    o_rclk,
  output logic                    o_rrst,
  output logic                    o_rgate,
  output logic                    o_ogate,
  input  wire fmd_pkg::fmd_word_t i_word,
  input  wire logic               i_oe,
  // Last sampled bus
  output logic [12:0]             o_seen
);
  import fmd_pkg::*;
  event      sampled;
  fmd_word_t last;
  fmd_word_t bus;
  // Floating bus shows the inverse of its last value
  assign bus = i_oe ? i_word : ~last;
  initial begin
    {o_wclk, o_wrst, o_wgate, o_imask, o_rclk, o_rrst, o_rgate, o_ogate} = '0;
    o_wdata = '0;
    o_seen  = '0;
    last    = '0;
  end
  // Pin clocks rest low between cycles
  task automatic wcyc(input logic rst, input logic g, input logic m, input fmd_word_t d);
    @(posedge i_core_clk);
    o_wrst  <= rst;
    o_wgate <= g;
    o_imask <= m;
    o_wdata <= d;
    repeat (4) @(posedge i_core_clk);
    o_wclk <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    o_wclk  <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic rcyc(input logic rst, input logic g, input logic og, input logic chk);
    @(posedge i_core_clk);
    o_rrst  <= rst;
    o_rgate <= g;
    o_ogate <= og;
    repeat (4) @(posedge i_core_clk);
    o_rclk <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    o_rclk <= 1'b0;
    o_seen = {i_oe, bus};
    last   = bus;
    if (chk) begin
      -> sampled;
    end
  endtask
endmodule
`default_nettype wire

// *** testbench/field_memory_delay_fifo_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "fmd_cfg.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module field_memory_delay_fifo_test;
  import fmd_pkg::*;
  logic        clk, rst, psel, pen, pwr, err, pready, pslverr, oe;
  logic        wclk, wrst, wg, im, rclk, rrst, rg, og;
  logic [11:0] paddr;
  logic [31:0] pwd, prd, rd;
  logic [12:0] e;
  logic [12:0] expq [$];
  fmd_word_t   wd, word, rv;
  fmd_word_t   exp_mem [0:1023];
  int          n_errors = 0, check_count = 0, cyc = 0, seed = 47;

  fmd_field_memory #(.DEPTH(1024), .ADDR_W(10), .DL_DEPTH(8), .FIFO_DEPTH(8)) u_dut (
    .i_core_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(pready), .o_pslverr(pslverr),
    .i_serial_write_clock(wclk), .i_write_pointer_reset(wrst), .i_write_gate(wg),
    .i_input_mask(im), .i_input_word(wd), .i_serial_read_clock(rclk),
    .i_read_pointer_reset(rrst), .i_read_gate(rg), .i_output_gate(og),
    .o_output_word(word), .o_output_word_oe(oe));
  fmd_video_drv u_drv (
    .i_core_clk(clk), .o_wclk(wclk), .o_wrst(wrst), .o_wgate(wg), .o_imask(im), .o_wdata(wd),
    .o_rclk(rclk), .o_rrst(rrst), .o_rgate(rg), .o_ogate(og), .i_word(word), .i_oe(oe),
    .o_seen());

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel  <= 1'b1;
    pen   <= 1'b0;
    pwr   <= w;
    paddr <= a;
    pwd   <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd  = prd;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic chkreg(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(rd, x)
  endtask
  task automatic rchk(input logic g, input logic o, input logic [12:0] x);
    expq.push_back(x);
    u_drv.rcyc(1'b0, g, o, 1'b1);
  endtask
  task automatic test_done();
    `CHK(expq.size(), 0)
    $display("Checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      $display("Error %0t: timeout", $time);
      test_done();
    end
  end
  // Read port results in issue order
  initial forever begin
    @(u_drv.sampled);
    e = expq.pop_front();
    `CHK(u_drv.o_seen[12] ? u_drv.o_seen : 13'h0, e)
  end
  initial begin
    {rst, psel, pen, pwr} = 4'h8;
    {paddr, pwd} = '0;
    rv = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // Reset values and unmapped access
    chkreg(`FMD_OFS_CTRL, 32'h1);
    chkreg(`FMD_OFS_WPTR, 32'h0);
    chkreg(`FMD_OFS_RPTR, 32'h0);
    chkreg(`FMD_OFS_LAG, 32'h0);
    apb(1'b1, 12'h010, 32'h1);
    `CHK(err, 1'b1)
    chkreg(12'h010, 32'h0);
    `CHK(err, 1'b1)
    // Double pointer reset after unsettled supply
    u_drv.wcyc(1'b1, 1'b0, 1'b0, 12'h000);
    for (int i = 0; i < 80; i++) begin
      exp_mem[i] = 12'(i);
      u_drv.wcyc(1'b0, 1'b1, 1'b1, exp_mem[i]);
    end
    chkreg(`FMD_OFS_WPTR, 32'h50);
    u_drv.wcyc(1'b1, 1'b1, 1'b1, 12'hABC);
    chkreg(`FMD_OFS_WPTR, 32'h0);
    u_drv.rcyc(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (80) u_drv.rcyc(1'b0, 1'b1, 1'b1, 1'b0);
    chkreg(`FMD_OFS_RPTR, 32'h50);
    u_drv.rcyc(1'b1, 1'b1, 1'b1, 1'b0);
    chkreg(`FMD_OFS_RPTR, 32'h0);
    // New field with a masked word and a gated-off cycle
    u_drv.wcyc(1'b1, 1'b0, 1'b0, 12'h000);
    for (int i = 0; i < 620; i++) begin
      rv = 12'($random(seed));
      if (i == 10) u_drv.wcyc(1'b0, 1'b0, 1'b1, ~rv);
      if (i != 5) exp_mem[i] = rv;
      u_drv.wcyc(1'b0, 1'b1, i != 5, rv);
    end
    chkreg(`FMD_OFS_WPTR, 32'h26C);
    u_drv.rcyc(1'b1, 1'b0, 1'b1, 1'b0);
    apb(1'b0, `FMD_OFS_LAG, 32'h0);
    `CHK(rd[17:16], 2'h2)
    for (int i = 0; i < 12; i++) rchk(1'b1, 1'b1, {1'b1, exp_mem[i]});
    rchk(1'b0, 1'b1, {1'b1, exp_mem[11]});
    chkreg(`FMD_OFS_RPTR, 32'hC);
    rchk(1'b1, 1'b0, 13'h0);
    chkreg(`FMD_OFS_RPTR, 32'hD);
    apb(1'b1, `FMD_OFS_CTRL, 32'h3);
    rchk(1'b1, 1'b1, 13'h0);
    apb(1'b1, `FMD_OFS_CTRL, 32'h1);
    rchk(1'b1, 1'b1, {1'b1, exp_mem[14]});
    // Early read reset still sees the earlier field
    u_drv.wcyc(1'b1, 1'b0, 1'b0, 12'h000);
    repeat (4) u_drv.wcyc(1'b0, 1'b1, 1'b1, 12'($random(seed)));
    u_drv.rcyc(1'b1, 1'b0, 1'b1, 1'b0);
    apb(1'b0, `FMD_OFS_LAG, 32'h0);
    `CHK(rd[17:16], 2'h1)
    for (int i = 0; i < 4; i++) rchk(1'b1, 1'b1, {1'b1, exp_mem[i]});
    // Mid lag: undetermined data, writes go on
    u_drv.wcyc(1'b1, 1'b0, 1'b0, 12'h000);
    for (int i = 0; i < 100; i++) begin
      exp_mem[i] = 12'($random(seed));
      u_drv.wcyc(1'b0, 1'b1, 1'b1, exp_mem[i]);
    end
    u_drv.rcyc(1'b1, 1'b0, 1'b1, 1'b0);
    apb(1'b0, `FMD_OFS_LAG, 32'h0);
    `CHK(rd[17:16], 2'h3)
    for (int i = 100; i < 105; i++) begin
      exp_mem[i] = 12'($random(seed));
      u_drv.wcyc(1'b0, 1'b1, 1'b1, exp_mem[i]);
    end
    chkreg(`FMD_OFS_WPTR, 32'h69);
    // Ports off, read-only pointer
    apb(1'b1, `FMD_OFS_CTRL, 32'h0);
    u_drv.wcyc(1'b0, 1'b1, 1'b1, 12'h000);
    apb(1'b1, `FMD_OFS_WPTR, 32'h0);
    chkreg(`FMD_OFS_WPTR, 32'h69);
    chkreg(`FMD_OFS_CTRL, 32'h0);
    apb(1'b1, `FMD_OFS_CTRL, 32'h1);
    // Read fetch one cycle behind each write edge stalls the commit queue
    for (int i = 0; i < 40; i++) begin
      exp_mem[105 + i] = 12'($random(seed));
      fork
        u_drv.wcyc(1'b0, 1'b1, 1'b1, exp_mem[105 + i]);
        begin
          @(posedge clk);
          rchk(1'b1, 1'b1, {1'b1, exp_mem[i]});
        end
      join
    end
    repeat (8) u_drv.wcyc(1'b0, 1'b1, 1'b1, 12'h000);
    for (int i = 40; i < 145; i++) rchk(1'b1, 1'b1, {1'b1, exp_mem[i]});
    chkreg(`FMD_OFS_LAG, 32'h00030064);
    chkreg(`FMD_OFS_RPTR, 32'h91);
    chkreg(`FMD_OFS_WPTR, 32'h99);
    test_done();
  end
endmodule
`default_nettype wire
